// *** design/vsr_channel.sv ***
// One sense channel: latest converter code, frozen copy and freshness flag.
// Assumes sample_valid is a one-cycle strobe from the converter.
`timescale 1ns/100ps
module vsr_channel (
  input wire logic clk,
  input wire logic srst,
  input wire logic [11:0] sample_code,
  input wire logic sample_valid,
  input wire logic freeze,
  input wire logic hold_en,
  output logic [15:0] reading,
  output logic [3:0] frozen_low,
  output logic fresh
);

  logic [11:0] live_code;
  logic [11:0] held_code;
  logic [11:0] next_held_code;
  logic next_fresh;

  // linear code
  // Code is the converter step count, so no rescaling is applied here
  assign reading = {live_code, vsr_pkg::RESERVED_VALUE};

  assign next_held_code = freeze ? live_code : held_code;

  // Set wins so a sample landing on the read is not missed
  assign next_fresh = sample_valid | (fresh & ~freeze);

  // low nibble source
  // With hold off the low bits follow the live code and may tear
  assign frozen_low = hold_en ? held_code[3:0] : live_code[3:0];

  always_ff @(posedge clk) begin
    if (srst) begin
      live_code <= vsr_pkg::CODE_RESET;
      held_code <= vsr_pkg::CODE_RESET;
      fresh <= 1'b0;
    end else begin
      if (sample_valid) begin
        live_code <= sample_code;
      end
      held_code <= next_held_code;
      fresh <= next_fresh;
    end
  end

endmodule : vsr_channel

// *** design/vsr_pkg.sv ***
// Constants for the output-voltage read-out block.
// Assumes a byte-wide register port and a 12-bit converter outside it.
package vsr_pkg;

  // ********************************
  // Register offsets
  // ********************************
  localparam logic [7:0] LOCAL_READING_OFFS = 8'h15;
  localparam logic [7:0] LOAD_READING_OFFS = 8'h16;
  localparam logic [7:0] READ_CTRL_OFFS = 8'h40;
  localparam logic [7:0] READ_STATUS_OFFS = 8'h41;

  // ********************************
  // Field layout
  // ********************************
  localparam int CODE_W = 12;
  localparam int READING_W = 16;
  localparam int BYTE_W = 8;
  localparam int RESULT_MSB = 15;
  localparam int RESULT_LSB = 4;
  localparam int RESERVED_W = 4;
  localparam int LOW_NIBBLE_W = 4;
  localparam int CTRL_HOLD_BIT = 0;
  localparam int STATUS_LOCAL_FRESH_BIT = 0;
  localparam int STATUS_LOAD_FRESH_BIT = 1;
  localparam int STATUS_SECOND_PEND_BIT = 2;

  // ********************************
  // Reset values
  // ********************************
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;
  localparam logic [3:0] RESERVED_VALUE = 4'h0;

  // ********************************
  // Converter scaling
  // ********************************
  localparam int FULL_SCALE_MV = 1550;
  localparam int LSB_UV = 378;
  localparam logic [11:0] CODE_AT_0V = 12'h000;
  localparam logic [11:0] CODE_AT_1V5 = 12'hf7c;
  localparam logic [11:0] CODE_AT_1V = 12'ha53;

  // ********************************
  // Byte phase of a two-read fetch
  // ********************************
  typedef enum logic [0:0] {
    VSR_PHASE_HIGH = 1'b0,
    VSR_PHASE_LOW = 1'b1
  } vsr_phase_e;

endpackage : vsr_pkg

// *** design/vsr_readout.sv ***
// Top of the output-voltage read-out: register port and two sense channels.
// Assumes a byte register port with one-cycle strobes and read data one
// cycle after the read strobe; converter codes arrive with a valid strobe.
`timescale 1ns/100ps

// Contract
// - local result in bits 15:4, low reserved
// - load result in separate register likewise
// - first read returns upper eight result bits
// - second read returns low nibble, top
// - linear scale, 378 uV per step
// - zero volts reads code zero
// - 1.5 volts gives code 3964
// - one volt reads code 2643
module vsr_readout (
  input wire logic clk,
  input wire logic srst,
  input wire logic [11:0] local_sense_pin_code,
  input wire logic local_sense_pin_valid,
  input wire logic [11:0] load_sense_pin_code,
  input wire logic load_sense_pin_valid,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [15:0] local_reading,
  output logic [15:0] load_reading
);

  // ********************************
  // Declarations
  // ********************************
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [7:0] next_rdata;
  logic [7:0] pend_addr;
  logic [7:0] next_pend_addr;
  vsr_pkg::vsr_phase_e phase;
  vsr_pkg::vsr_phase_e next_phase;
  wire logic hold_en;
  wire logic hit_local;
  wire logic hit_load;
  wire logic hit_ctrl;
  wire logic hit_status;
  wire logic hit_reading;
  wire logic second_read;
  wire logic first_read;
  wire logic freeze_local;
  wire logic freeze_load;
  wire logic [15:0] local_word;
  wire logic [15:0] load_word;
  wire logic [3:0] local_low;
  wire logic [3:0] load_low;
  wire logic local_fresh;
  wire logic load_fresh;
  wire logic [7:0] status_byte;
  wire logic [7:0] high_byte;
  wire logic [7:0] low_byte;
  wire logic [7:0] reading_byte;

  function automatic logic [7:0] upper_byte(input logic [15:0] word);
    upper_byte = word[vsr_pkg::RESULT_MSB -: vsr_pkg::BYTE_W];
  endfunction : upper_byte

  function automatic logic [7:0] low_nibble_byte(input logic [3:0] nib);
    low_nibble_byte = {nib, vsr_pkg::RESERVED_VALUE};
  endfunction : low_nibble_byte

  // ********************************
  // Address decode
  // ********************************
  assign hit_local = (reg_addr == vsr_pkg::LOCAL_READING_OFFS);
  assign hit_load = (reg_addr == vsr_pkg::LOAD_READING_OFFS);
  assign hit_ctrl = (reg_addr == vsr_pkg::READ_CTRL_OFFS);
  assign hit_status = (reg_addr == vsr_pkg::READ_STATUS_OFFS);
  assign hit_reading = hit_local | hit_load;
  assign hold_en = ctrl[vsr_pkg::CTRL_HOLD_BIT];

  // pair tracking
  // Any other access between the two reads restarts the pair
  assign second_read = reg_rd & hit_reading & (phase == vsr_pkg::VSR_PHASE_LOW)
                       & (reg_addr == pend_addr);
  assign first_read = reg_rd & hit_reading & ~second_read;

  assign freeze_local = first_read & hit_local;
  assign freeze_load = first_read & hit_load;

  always_comb begin
    next_phase = phase;
    next_pend_addr = pend_addr;
    if (reg_wr | (reg_rd & ~hit_reading)) begin
      next_phase = vsr_pkg::VSR_PHASE_HIGH;
    end else if (first_read) begin
      next_phase = vsr_pkg::VSR_PHASE_LOW;
      next_pend_addr = reg_addr;
    end else if (second_read) begin
      next_phase = vsr_pkg::VSR_PHASE_HIGH;
    end
  end

  // ********************************
  // Sense channels
  // ********************************
  // local channel
  vsr_channel u_local (
    .clk(clk),
    .srst(srst),
    .sample_code(local_sense_pin_code),
    .sample_valid(local_sense_pin_valid),
    .freeze(freeze_local),
    .hold_en(hold_en),
    .reading(local_word),
    .frozen_low(local_low),
    .fresh(local_fresh)
  );

  vsr_channel u_load (
    .clk(clk),
    .srst(srst),
    .sample_code(load_sense_pin_code),
    .sample_valid(load_sense_pin_valid),
    .freeze(freeze_load),
    .hold_en(hold_en),
    .reading(load_word),
    .frozen_low(load_low),
    .fresh(load_fresh)
  );

  // ********************************
  // Read data selection
  // ********************************
  // upper eight bits
  assign high_byte = hit_local ? upper_byte(local_word) : upper_byte(load_word);

  assign low_byte = hit_local ? low_nibble_byte(local_low) : low_nibble_byte(load_low);

  assign reading_byte = second_read ? low_byte : high_byte;

  assign status_byte = {5'h00,
                        (phase == vsr_pkg::VSR_PHASE_LOW),
                        load_fresh,
                        local_fresh};

  assign next_rdata = !reg_rd ? vsr_pkg::RDATA_RESET :
                      hit_reading ? reading_byte :
                      hit_ctrl ? ctrl :
                      hit_status ? status_byte :
                      vsr_pkg::UNMAPPED_RDATA;

  // Only the hold bit is writable; the reading registers ignore writes
  assign next_ctrl = (reg_wr & hit_ctrl) ? {7'h00, reg_wdata[vsr_pkg::CTRL_HOLD_BIT]} : ctrl;

  // ********************************
  // Registers
  // ********************************
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl <= vsr_pkg::CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      phase <= vsr_pkg::VSR_PHASE_HIGH;
      pend_addr <= 8'h00;
    end else begin
      phase <= next_phase;
      pend_addr <= next_pend_addr;
    end
  end

  // byte one cycle on
  // Idle cycles return zero so a stale byte is never read twice
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= vsr_pkg::RDATA_RESET;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Mirrors keep every top output on a flip-flop
  always_ff @(posedge clk) begin
    if (srst) begin
      local_reading <= {vsr_pkg::CODE_RESET, vsr_pkg::RESERVED_VALUE};
      load_reading <= {vsr_pkg::CODE_RESET, vsr_pkg::RESERVED_VALUE};
    end else begin
      local_reading <= local_word;
      load_reading <= load_word;
    end
  end

endmodule : vsr_readout

// *** testbench/vsr_assertions.sv ***
// Port checker for the read-out.
// Assumes it sees every top port; the hold bit is mirrored from writes.
`timescale 1ns/100ps
module vsr_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic [11:0] local_sense_pin_code,
  input wire logic local_sense_pin_valid,
  input wire logic [11:0] load_sense_pin_code,
  input wire logic load_sense_pin_valid,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [15:0] local_reading,
  input wire logic [15:0] load_reading
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire rl = reg_rd && reg_addr == vsr_pkg::LOCAL_READING_OFFS;
  wire rd2 = reg_rd && reg_addr == vsr_pkg::LOAD_READING_OFFS;
  wire rmap = rl || rd2 || reg_addr == vsr_pkg::READ_CTRL_OFFS
    || reg_addr == vsr_pkg::READ_STATUS_OFFS;
  wire quiet = !reg_wr && !reg_rd;
  logic hold_seen;
  // Mirror of the hold bit, so the low-nibble checks know their source
  always_ff @(posedge clk) begin
    if (srst) begin
      hold_seen <= vsr_pkg::CTRL_RESET[vsr_pkg::CTRL_HOLD_BIT];
    end else if (reg_wr && reg_addr == vsr_pkg::READ_CTRL_OFFS) begin
      hold_seen <= reg_wdata[vsr_pkg::CTRL_HOLD_BIT];
    end
  end
  property p_lmap;
    local_sense_pin_valid ##1 !local_sense_pin_valid
      |-> ##1 local_reading == {$past(local_sense_pin_code, 2), 4'h0};
  endproperty
  a_lmap: assert property (p_lmap) else $error("local map");
  property p_dmap;
    load_sense_pin_valid ##1 !load_sense_pin_valid
      |-> ##1 load_reading == {$past(load_sense_pin_code, 2), 4'h0};
  endproperty
  a_dmap: assert property (p_dmap) else $error("load map");
  property p_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("idle data");
  property p_unmap;
    reg_rd && !rmap |=> reg_rdata == vsr_pkg::UNMAPPED_RDATA;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped");
  property p_lhi;
    rd2 ##1 !rl ##1 rl |=> reg_rdata == local_reading[15:8];
  endproperty
  a_lhi: assert property (p_lhi) else $error("local high");
  property p_dhi;
    rl ##1 !rd2 ##1 rd2 |=> reg_rdata == load_reading[15:8];
  endproperty
  a_dhi: assert property (p_dhi) else $error("load high");
  property p_llo;
    rd2 ##1 !rl ##1 (rl && hold_seen) ##1 quiet ##1 rl
      |=> reg_rdata == {$past(local_reading[7:4], 2), 4'h0};
  endproperty
  a_llo: assert property (p_llo) else $error("local low");
  property p_dlo;
    rl ##1 !rd2 ##1 (rd2 && hold_seen) ##1 quiet ##1 rd2
      |=> reg_rdata == {$past(load_reading[7:4], 2), 4'h0};
  endproperty
  a_dlo: assert property (p_dlo) else $error("load low");
endmodule : vsr_chk
bind vsr_readout vsr_chk vsr_chk_i (.clk(clk), .srst(srst),
  .local_sense_pin_code(local_sense_pin_code), .local_sense_pin_valid(local_sense_pin_valid),
  .load_sense_pin_code(load_sense_pin_code), .load_sense_pin_valid(load_sense_pin_valid),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .local_reading(local_reading), .load_reading(load_reading));

// *** testbench/vsr_conv_model.sv ***
// Converter model driving both sense channels.
// Assumes go is a one-cycle request from the bench.
`timescale 1ns/100ps
module vsr_conv_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic go,
  input wire logic [11:0] code_in_a,
  input wire logic [11:0] code_in_b,
  output logic [11:0] code_a,
  output logic [11:0] code_b,
  output logic valid
);
  // Codes invert outside the strobe, so a stale code is never taken for valid
  always_ff @(posedge clk) begin
    valid <= go && !srst;
    code_a <= go ? code_in_a : ~code_a;
    code_b <= go ? code_in_b : ~code_b;
  end
endmodule : vsr_conv_model

// *** testbench/vsr_readout_tb.sv ***
// Self-checking bench for the read-out.
// Assumes the converter model and the bound checker.
`timescale 1ns/100ps
module vsr_readout_tb;
  logic clk = 0, srst = 1, go = 0, reg_wr = 0, reg_rd = 0, lv;
  logic [11:0] ca = 0, cb = 0, lc, dc, v;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic [15:0] local_reading, load_reading;
  logic [31:0] seed = 32'hbd05;
  int err_count = 0, num_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  vsr_conv_model vsr_conv_model_i (.clk(clk), .srst(srst), .go(go), .code_in_a(ca),
    .code_in_b(cb), .code_a(lc), .code_b(dc), .valid(lv));
  vsr_readout vsr_readout_i (.clk(clk), .srst(srst), .local_sense_pin_code(lc),
    .local_sense_pin_valid(lv), .load_sense_pin_code(dc), .load_sense_pin_valid(lv),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .local_reading(local_reading), .load_reading(load_reading));
  function logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // Byte returned by the first or the second read of a pair
  function logic [7:0] bt(input logic [11:0] c, input logic lo);
    return lo ? {c[3:0], 4'h0} : c[11:4];
  endfunction : bt
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", {8'h00, reg_rdata}, {8'h00, e});
  endtask : rd
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task sense(input logic [11:0] a, input logic [11:0] b);
    @(posedge clk);
    go <= 1'b1;
    ca <= a;
    cb <= b;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("local", local_reading, {a, 4'h0});
    chk("load", load_reading, {b, 4'h0});
  endtask : sense
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      v = (i == 0) ? 12'h000 : (i == 1) ? 12'hf7c : (i == 2) ? 12'ha53 : seed[11:0];
      sense(v, ~v);
      rd(8'h16, bt(~v, 0));
      rd(8'h15, bt(v, 0));
      rd(8'h15, bt(v, 1));
      rd(8'h16, bt(~v, 0));
      rd(8'h16, bt(~v, 1));
    end
    $display("test pairs done");
    sense(12'h5a3, 12'h000);
    rd(8'h15, 8'h5a);
    sense(12'ha5c, 12'h000);
    rd(8'h15, 8'h30);
    rd(8'h15, 8'ha5);
    wr(8'h15, seed[7:0]);
    rd(8'h15, 8'ha5);
    wr(8'h40, 8'h01);
    rd(8'h40, 8'h01);
    rd(8'h20, 8'h00);
    // Status flags, then a tearing pair with hold off
    sense(12'h3c7, 12'h000);
    rd(8'h41, 8'h03);
    rd(8'h15, 8'h3c);
    rd(8'h41, 8'h06);
    wr(8'h40, 8'h00);
    rd(8'h40, 8'h00);
    rd(8'h15, 8'h3c);
    sense(12'h8e1, 12'h000);
    rd(8'h15, 8'h10);
    $display("test freeze done");
    close_out();
  end
endmodule : vsr_readout_tb
